// >>> design/urm_map.vh
// Register map, field positions, reset values and trigger table of the UART register block.
`ifndef URM_MAP_VH
`define URM_MAP_VH

// Register addresses on the three-bit host port.
`define URM_A_DATA      3'h0
`define URM_A_MASK      3'h1
`define URM_A_STAT      3'h2
`define URM_A_LCTL      3'h3
`define URM_A_MCTL      3'h4
`define URM_A_LSTAT     3'h5
`define URM_A_MSTAT     3'h6
`define URM_A_SCRATCH   3'h7

// Line control value that opens the enhanced register page.
`define URM_LCR_KEY     8'hBF
`define URM_LCR_DLAB    7

// Enhanced function bit that unlocks the upper control bits.
`define URM_EFR_ENH     4

// Feature control fields.
`define URM_FEATURE_CONTROL_RXSEL  7
`define URM_FEATURE_CONTROL_SWAP   6
`define URM_FEATURE_CONTROL_TBL_HI 5
`define URM_FEATURE_CONTROL_TBL_LO 4

// Fifo control fields.
`define URM_FCR_EN      0
`define URM_FCR_RXRST   1
`define URM_FCR_TXRST   2

// Reset values.
`define URM_RST_BYTE    8'h00
`define URM_RST_TRIG    8'h01

// Receive trigger levels picked by fifo control bits 7:6.
`define URM_TRIG_L0     8'h01
`define URM_TRIG_L1     8'h04
`define URM_TRIG_L2     8'h08
`define URM_TRIG_L3     8'h0E

// Interrupt status codes in bits 5:0, highest priority first.
`define URM_ISR_LINE    6'h06
`define URM_ISR_RXDATA  6'h04
`define URM_ISR_TXRDY   6'h02
`define URM_ISR_MODEM   6'h00
`define URM_ISR_XOFF    6'h10
`define URM_ISR_FLOW    6'h20
`define URM_ISR_NONE    6'h01

`endif

// >>> design/urm_rx_fifo.v
// Receive fifo holding each character with its error tags and a count of tagged entries.
`timescale 1ns/10ps
`default_nettype none
module urm_rx_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 64,
  parameter AW    = 6
)(
  // Clock and reset.
  input  wire             sys_clk,
  input  wire             rst_n,
  // Control.
  input  wire             clear,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  // Status.
  output wire [WIDTH-1:0] head,
  output reg  [AW:0]      fill,
  output wire             full,
  output reg  [AW:0]      err_count
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  wire            do_push;
  wire            do_pop;
  wire            push_err;
  wire            pop_err;

  // The three low bits of each entry are its error tags.
  assign head     = mem[rd_ptr_reg];
  assign full     = (fill == DEPTH);
  assign do_push  = push & ~full;
  assign do_pop   = pop & (fill != 0);
  assign push_err = |push_data[2:0];
  assign pop_err  = |head[2:0];

  // Storage has no reset; only valid entries are ever read.
  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  // Pointers, fill level and tagged-entry count move together.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      fill       <= {(AW+1){1'b0}};
      err_count  <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      fill       <= {(AW+1){1'b0}};
      err_count  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      fill      <= fill + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      err_count <= err_count + {{AW{1'b0}}, do_push & push_err} - {{AW{1'b0}}, do_pop & pop_err};
    end
  end

endmodule
`default_nettype wire

// >>> design/urm_regs.v
// Register map and receive interrupt and line status logic of one UART channel.
//
// How it works
// - Divisor access maps divisor bytes at 0, 1.
// - Enhanced key opens page; enable gates upper bits.
// - Mask bits gate sources into interrupt status.
// - Receive interrupt follows fill versus trigger level.
// - Status code clears with interrupt below trigger.
// - Data ready set on push, clears when empty.
// - Fifo on, mask bits clear: polled mode.
// - Separate receive and transmit line status bits.
// - Overrun sets line status bit one.
// - Error bits belong to the head character.
// - Bit five shows transmit holding empty, or transmit fifo empty in fifo mode.
// - Bit six: transmit fifo (holding without fifos) and shifter empty.
// - Bit seven: any tagged character in fifo.
// - Non-fifo interrupt whenever a character waits.
// - Interrupt mask resets to zero.
`timescale 1ns/10ps
`default_nettype none
`include "urm_map.vh"
module urm_regs #(
  parameter       DEPTH        = 64,
  parameter       AW           = 6,
  parameter [7:0] DEV_REVISION = 8'h01, // Arbitrary value.
  parameter [7:0] DEV_IDENTITY = 8'h5A  // Arbitrary value.
)(
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_n,
  // Host register port.
  input  wire [2:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Receiver datapath.
  input  wire        rx_push,
  input  wire [7:0]  rx_push_data,
  input  wire [2:0]  rx_push_err,
  // Transmitter status and data.
  input  wire        tx_hold_empty,
  input  wire        tx_fifo_empty,
  input  wire        tx_shift_empty,
  input  wire [7:0]  tx_fill,
  output reg         tx_write,
  output reg  [7:0]  tx_data,
  output reg         tx_fifo_clear,
  // Modem status and other interrupt sources.
  input  wire [7:0]  modem_status,
  input  wire        modem_event,
  input  wire        xoff_event,
  input  wire        flow_event,
  // Configuration towards the channel.
  output wire [15:0] divisor,
  output reg  [7:0]  line_control,
  output reg  [7:0]  modem_control,
  output reg  [7:0]  feature_control,
  output reg  [7:0]  enhanced_function,
  output reg  [7:0]  resume_char_one,
  output reg  [7:0]  resume_char_two,
  output reg  [7:0]  pause_char_one,
  output reg  [7:0]  pause_char_two,
  output wire        fifo_enable,
  // Interrupt request, active high.
  output reg         irq
);

  reg  [7:0]  divisor_low_byte;
  reg  [7:0]  divisor_high_byte;
  reg  [7:0]  interrupt_mask;
  reg  [7:0]  fifo_control;
  reg  [7:0]  fifo_trigger_level;
  reg  [7:0]  scratch_reg;
  reg         overrun_reg;
  reg  [7:0]  rd_next;
  reg  [5:0]  isr_code;
  reg  [7:0]  trig_level;

  wire [10:0] head;
  wire [AW:0] fill;
  wire [AW:0] err_count;
  wire        fifo_full;
  wire        eff_full;
  wire        fifo_push;
  wire        fifo_pop;
  wire        rx_clear;
  wire        enh_page;
  wire        dl_page;
  wire        id_view;
  wire        enh_en;
  wire [7:0]  fill8;
  wire [7:0]  line_status;
  wire [7:0]  interrupt_status;
  wire [7:0]  fifo_fill_count;
  wire        rx_avail;
  wire        line_int;
  wire        rx_int;
  wire        tx_int;
  wire        modem_int;
  wire        xoff_int;
  wire        flow_int;
  wire        wr_norm;
  wire        rd_norm;

  // Page decode from the line control register.
  assign enh_page = (line_control == `URM_LCR_KEY);
  assign dl_page  = line_control[`URM_LCR_DLAB] & ~enh_page;
  assign id_view  = dl_page & (divisor_low_byte == 8'h00) & (divisor_high_byte == 8'h00);
  assign enh_en   = enhanced_function[`URM_EFR_ENH];
  assign wr_norm  = reg_wr & ~enh_page & ~dl_page;
  assign rd_norm  = reg_rd & ~enh_page & ~dl_page;
  assign divisor  = {divisor_high_byte, divisor_low_byte};
  assign fifo_enable = fifo_control[`URM_FCR_EN];

  // Without fifos the receiver holds one character, so a second one overruns.
  assign eff_full  = fifo_enable ? fifo_full : (fill != 0);
  assign fifo_push = rx_push & ~eff_full;
  assign fifo_pop  = reg_rd & (reg_addr == `URM_A_DATA) & ~enh_page & ~dl_page;
  assign rx_clear  = reg_wr & wr_norm & (reg_addr == `URM_A_STAT) &
                     reg_wdata[`URM_FCR_EN] & reg_wdata[`URM_FCR_RXRST];

  urm_rx_fifo #(
    .WIDTH (11),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clear     (rx_clear),
    .push      (fifo_push),
    .push_data ({rx_push_data, rx_push_err}),
    .pop       (fifo_pop),
    .head      (head),
    .fill      (fill),
    .full      (fifo_full),
    .err_count (err_count)
  );

  assign fill8 = {{(7-AW){1'b0}}, fill};

  // Trigger comes from the programmable register when the table select asks for it.
  always @* begin
    if (feature_control[`URM_FEATURE_CONTROL_TBL_HI] & feature_control[`URM_FEATURE_CONTROL_TBL_LO]) begin
      trig_level = fifo_trigger_level;
    end else begin
      case (fifo_control[7:6])
        2'b00:   trig_level = `URM_TRIG_L0;
        2'b01:   trig_level = `URM_TRIG_L1;
        2'b10:   trig_level = `URM_TRIG_L2;
        default: trig_level = `URM_TRIG_L3;
      endcase
    end
  end

  // Each direction has its own status bits so either can be polled alone.
  assign line_status[0] = (fill != 0);
  assign line_status[1] = overrun_reg;
  assign line_status[4:2] = (fill != 0) ? head[2:0] : 3'b000;
  assign line_status[5] = fifo_enable ? tx_fifo_empty : tx_hold_empty;
  assign line_status[6] = (fifo_enable ? tx_fifo_empty : tx_hold_empty) & tx_shift_empty;
  assign line_status[7] = fifo_enable ? (err_count != 0) : ((fill != 0) & (|head[2:0]));

  // Receive data interrupt: trigger level in fifo mode, any character otherwise.
  assign rx_avail = fifo_enable ? (fill8 >= trig_level) : (fill != 0);
  assign rx_int    = interrupt_mask[0] & rx_avail;
  assign line_int  = interrupt_mask[2] & (|line_status[4:1]);
  assign tx_int    = interrupt_mask[1] & line_status[5];
  assign modem_int = interrupt_mask[3] & modem_event;
  assign xoff_int  = enh_en & interrupt_mask[5] & xoff_event;
  assign flow_int  = enh_en & (interrupt_mask[6] | interrupt_mask[7]) & flow_event;

  // Highest pending source wins the status code; all mask bits clear leaves only polling.
  always @* begin
    if (line_int) begin
      isr_code = `URM_ISR_LINE;
    end else if (rx_int) begin
      isr_code = `URM_ISR_RXDATA;
    end else if (tx_int) begin
      isr_code = `URM_ISR_TXRDY;
    end else if (modem_int) begin
      isr_code = `URM_ISR_MODEM;
    end else if (xoff_int) begin
      isr_code = `URM_ISR_XOFF;
    end else if (flow_int) begin
      isr_code = `URM_ISR_FLOW;
    end else begin
      isr_code = `URM_ISR_NONE;
    end
  end

  assign interrupt_status = {fifo_enable, fifo_enable, isr_code};
  assign fifo_fill_count  = feature_control[`URM_FEATURE_CONTROL_RXSEL] ? fill8 : tx_fill;

  // Read multiplexer; the write-only trigger shares its address with the fill count.
  always @* begin
    case (reg_addr)
      `URM_A_DATA: begin
        if (enh_page) begin
          rd_next = fifo_fill_count;
        end else if (dl_page) begin
          rd_next = id_view ? DEV_REVISION : divisor_low_byte;
        end else begin
          rd_next = (fill != 0) ? head[10:3] : 8'h00;
        end
      end
      `URM_A_MASK: begin
        if (enh_page) begin
          rd_next = feature_control;
        end else if (dl_page) begin
          rd_next = id_view ? DEV_IDENTITY : divisor_high_byte;
        end else begin
          rd_next = interrupt_mask;
        end
      end
      `URM_A_STAT:    rd_next = enh_page ? enhanced_function : interrupt_status;
      `URM_A_LCTL:    rd_next = line_control;
      `URM_A_MCTL:    rd_next = enh_page ? resume_char_one : modem_control;
      `URM_A_LSTAT:   rd_next = enh_page ? resume_char_two : line_status;
      `URM_A_MSTAT:   rd_next = enh_page ? pause_char_one : modem_status;
      `URM_A_SCRATCH: begin
        if (enh_page) begin
          rd_next = pause_char_two;
        end else begin
          rd_next = feature_control[`URM_FEATURE_CONTROL_SWAP] ? fill8 : scratch_reg;
        end
      end
      default:        rd_next = 8'h00;
    endcase
  end

  // Read data is captured on the strobe edge and held until the next read.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rd_next;
      end
      irq <= ~isr_code[0];
    end
  end

  // Overrun is sticky until a line status read outside the divisor and enhanced pages; a new overrun in that cycle wins.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (rx_push & eff_full) begin
      overrun_reg <= 1'b1;
    end else if (rd_norm & (reg_addr == `URM_A_LSTAT)) begin
      overrun_reg <= 1'b0;
    end
  end

  // Register writes; bits behind the enhanced enable only take writes while it is set.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_low_byte   <= `URM_RST_BYTE;
      divisor_high_byte  <= `URM_RST_BYTE;
      interrupt_mask     <= `URM_RST_BYTE;
      fifo_control       <= `URM_RST_BYTE;
      fifo_trigger_level <= `URM_RST_TRIG;
      line_control       <= `URM_RST_BYTE;
      modem_control      <= `URM_RST_BYTE;
      feature_control    <= `URM_RST_BYTE;
      enhanced_function  <= `URM_RST_BYTE;
      resume_char_one    <= `URM_RST_BYTE;
      resume_char_two    <= `URM_RST_BYTE;
      pause_char_one     <= `URM_RST_BYTE;
      pause_char_two     <= `URM_RST_BYTE;
      scratch_reg        <= `URM_RST_BYTE;
      tx_write           <= 1'b0;
      tx_data            <= 8'h00;
      tx_fifo_clear      <= 1'b0;
    end else begin
      tx_write      <= 1'b0;
      tx_fifo_clear <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `URM_A_DATA: begin
            if (enh_page) begin
              fifo_trigger_level <= reg_wdata;
            end else if (dl_page) begin
              divisor_low_byte <= reg_wdata;
            end else begin
              tx_write <= 1'b1;
              tx_data  <= reg_wdata;
            end
          end
          `URM_A_MASK: begin
            if (enh_page) begin
              feature_control <= reg_wdata;
            end else if (dl_page) begin
              divisor_high_byte <= reg_wdata;
            end else begin
              interrupt_mask <= {enh_en ? reg_wdata[7:4] : interrupt_mask[7:4], reg_wdata[3:0]};
            end
          end
          `URM_A_STAT: begin
            if (enh_page) begin
              enhanced_function <= reg_wdata;
            end else if (reg_wdata[`URM_FCR_EN]) begin
              // Other fields only load while the enable bit is written as one.
              fifo_control  <= {reg_wdata[7:6], enh_en ? reg_wdata[5:4] : fifo_control[5:4],
                                reg_wdata[3], 2'b00, 1'b1};
              tx_fifo_clear <= reg_wdata[`URM_FCR_TXRST];
            end else begin
              fifo_control[`URM_FCR_EN] <= 1'b0;
            end
          end
          `URM_A_LCTL: line_control <= reg_wdata;
          `URM_A_MCTL: begin
            if (enh_page) begin
              resume_char_one <= reg_wdata;
            end else begin
              modem_control <= {enh_en ? reg_wdata[7:5] : modem_control[7:5], reg_wdata[4:0]};
            end
          end
          `URM_A_LSTAT: begin
            if (enh_page) begin
              resume_char_two <= reg_wdata;
            end
          end
          `URM_A_MSTAT: begin
            if (enh_page) begin
              pause_char_one <= reg_wdata;
            end
          end
          `URM_A_SCRATCH: begin
            if (enh_page) begin
              pause_char_two <= reg_wdata;
            end else if (~feature_control[`URM_FEATURE_CONTROL_SWAP]) begin
              scratch_reg <= reg_wdata;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/urm_regs_props.sv
// Concurrent checks on the host port and configuration outputs of the register block.
`timescale 1ns/10ps
`default_nettype none
module urm_regs_props (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Host register port.
  input wire logic [2:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // Transmitter status.
  input wire logic        tx_hold_empty,
  input wire logic        tx_fifo_empty,
  input wire logic        tx_shift_empty,
  // Configuration outputs.
  input wire logic [15:0] divisor,
  input wire logic [7:0]  line_control,
  input wire logic [7:0]  modem_control,
  input wire logic [7:0]  enhanced_function,
  input wire logic [7:0]  resume_char_one,
  // Transmit strobes and fifo mode.
  input wire logic        fifo_enable,
  input wire logic        tx_write,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_fifo_clear
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Page decode and transmit conditions seen by the line status read.
  wire enh_page = (line_control == 8'hBF);
  wire tx_room  = fifo_enable ? tx_fifo_empty : tx_hold_empty;
  wire tx_idle  = tx_room & tx_shift_empty;

  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_lctl_write: assert property (reg_wr && reg_addr == 3'h3 |=> line_control == $past(reg_wdata))
    else $error("line control not written");
  a_div_low: assert property (reg_wr && reg_addr == 3'h0 && line_control[7] && !enh_page
    |=> divisor[7:0] == $past(reg_wdata)) else $error("divisor low byte not written");
  a_div_high: assert property (reg_wr && reg_addr == 3'h1 && line_control[7] && !enh_page
    |=> divisor[15:8] == $past(reg_wdata)) else $error("divisor high byte not written");
  a_div_kept_enh: assert property (reg_wr && enh_page |=> $stable(divisor))
    else $error("enhanced page write reached the divisor");
  a_efr_write: assert property (reg_wr && enh_page && reg_addr == 3'h2
    |=> enhanced_function == $past(reg_wdata)) else $error("enhanced function not written");
  a_resume_write: assert property (reg_wr && enh_page && reg_addr == 3'h4
    |=> resume_char_one == $past(reg_wdata)) else $error("resume character not written");
  a_mctl_gated: assert property (reg_wr && !enh_page && reg_addr == 3'h4 && !enhanced_function[4]
    |=> $stable(modem_control[7:5])) else $error("locked modem control bits changed");
  a_lstat_room: assert property (reg_rd && !enh_page && reg_addr == 3'h5
    |=> reg_rdata[5] == $past(tx_room)) else $error("line status bit five wrong");
  a_lstat_idle: assert property (reg_rd && !enh_page && reg_addr == 3'h5
    |=> reg_rdata[6] == $past(tx_idle)) else $error("line status bit six wrong");
  a_tx_strobe: assert property (reg_wr && reg_addr == 3'h0 && !line_control[7]
    |=> tx_write && tx_data == $past(reg_wdata)) else $error("transmit data write not passed on");
  a_fifo_mode: assert property (reg_wr && reg_addr == 3'h2 && !enh_page
    |=> fifo_enable == $past(reg_wdata[0])) else $error("fifo enable not written");
  a_tx_clear: assert property (reg_wr && reg_addr == 3'h2 && !enh_page && reg_wdata[0] && reg_wdata[2]
    |=> tx_fifo_clear) else $error("transmit fifo clear missing");
endmodule

bind urm_regs urm_regs_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_hold_empty(tx_hold_empty),
  .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty), .divisor(divisor),
  .line_control(line_control), .modem_control(modem_control),
  .enhanced_function(enhanced_function), .resume_char_one(resume_char_one),
  .fifo_enable(fifo_enable), .tx_write(tx_write), .tx_data(tx_data), .tx_fifo_clear(tx_fifo_clear)
);
`default_nettype wire

// >>> testbench/urm_host.sv
// Host processor model issuing one-cycle register strobes on the parallel port.
`timescale 1ns/10ps
`default_nettype none
module urm_host (
  // Clock.
  input  wire logic       sys_clk,
  // Register port towards the device.
  output var  logic [2:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus; released data carries the inverse so a stale value never looks valid.
  initial begin
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // Write strobe lasts exactly one cycle, as the port takes a write on every cycle the strobe is high.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // Read data is registered at the strobe edge and taken just after it.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_urm_regs.sv
// Self-checking testbench of the UART register map and receive status block.
`timescale 1ns/10ps
`default_nettype none
module tb_urm_regs;
  logic       sys_clk;
  logic       rst_n;
  logic [2:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       rx_push;
  logic [7:0] rx_push_data;
  logic [2:0] rx_push_err;
  logic       tx_hold_empty;
  logic       tx_fifo_empty;
  logic       tx_shift_empty;
  logic [7:0] tx_fill;
  logic [7:0] modem_status;
  logic       ev;
  logic       irq;
  int         bad_count;
  int         compares;
  int         k;
  logic [7:0] masks [4] = '{8'h02, 8'h08, 8'h20, 8'hC0};
  logic [7:0] codes [4] = '{8'h02, 8'h00, 8'h10, 8'h20};

  // Small fifo keeps the overrun case short; identity values are arbitrary.
  urm_regs #(.DEPTH(8), .AW(3), .DEV_REVISION(8'h3C), .DEV_IDENTITY(8'hC3)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_push(rx_push), .rx_push_data(rx_push_data),
    .rx_push_err(rx_push_err), .tx_hold_empty(tx_hold_empty), .tx_fifo_empty(tx_fifo_empty),
    .tx_shift_empty(tx_shift_empty), .tx_fill(tx_fill), .tx_write(), .tx_data(), .tx_fifo_clear(),
    .modem_status(modem_status), .modem_event(ev), .xoff_event(ev), .flow_event(ev), .divisor(),
    .line_control(), .modem_control(), .feature_control(), .enhanced_function(),
    .resume_char_one(), .resume_char_two(), .pause_char_one(), .pause_char_two(),
    .fifo_enable(), .irq(irq));

  urm_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Clock at 250 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Verdict and end of run, reached from the main sequence and from the guards.
  task automatic summarize;
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask

  // Receiver hands one character to the block for one cycle.
  task automatic push(input logic [7:0] d, input logic [2:0] e);
    @(posedge sys_clk);
    #1;
    rx_push = 1'b1;
    rx_push_data = d;
    rx_push_err = e;
    @(posedge sys_clk);
    #1;
    rx_push = 1'b0;
    rx_push_data = ~d;
  endtask

  // Bounded wait for the interrupt line; a miss ends the run.
  task automatic wirq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({7'h00, irq}, {7'h00, exp});
    if (irq !== exp)
      summarize();
  endtask

  // Guard against a hung sequence.
  initial begin
    #100000;
    bad_count++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    rx_push = 1'b0;
    rx_push_data = 8'h00;
    rx_push_err = 3'h0;
    tx_hold_empty = 1'b1;
    tx_fifo_empty = 1'b1;
    tx_shift_empty = 1'b1;
    tx_fill = 8'h07;
    modem_status = 8'hA5;
    ev = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    rc(3'h1, 8'h00);
    // Divisor page: identity bytes only while both divisor bytes are zero.
    host.wr(3'h3, 8'h80);
    rc(3'h0, 8'h3C);
    rc(3'h1, 8'hC3);
    host.wr(3'h4, 8'hE0);
    host.wr(3'h0, 8'h34);
    rc(3'h1, 8'h00);
    host.wr(3'h1, 8'h12);
    rc(3'h0, 8'h34);
    rc(3'h1, 8'h12);
    // Enhanced page; the trigger write must not show on the shared read.
    host.wr(3'h3, 8'hBF);
    host.wr(3'h2, 8'h10);
    host.wr(3'h1, 8'h00);
    host.wr(3'h0, 8'hAA);
    rc(3'h0, 8'h07);
    rc(3'h2, 8'h10);
    for (k = 4; k < 8; k++) host.wr(k[2:0], 8'h40 + k[7:0]);
    for (k = 4; k < 8; k++) rc(k[2:0], 8'h40 + k[7:0]);
    // Fifo mode, trigger of four, receive interrupt on.
    host.wr(3'h3, 8'h03);
    host.wr(3'h1, 8'hE1);
    rc(3'h1, 8'hE1);
    host.wr(3'h2, 8'h41);
    for (k = 0; k < 3; k++) push(8'h10 + k[7:0], 3'h0);
    rc(3'h2, 8'hC1);
    push(8'h13, 3'h0);
    wirq(1'b1);
    rc(3'h2, 8'hC4);
    rc(3'h5, 8'h61);
    rc(3'h0, 8'h10);
    wirq(1'b0);
    rc(3'h2, 8'hC1);
    for (k = 1; k < 4; k++) rc(3'h0, 8'h10 + k[7:0]);
    rc(3'h5, 8'h60);
    // Error tags follow the head character; bit seven while any remain.
    for (k = 0; k < 3; k++) push(8'h20 + k[7:0], 3'h1 << k[1:0]);
    for (k = 0; k < 3; k++) begin
      rc(3'h5, 8'hE1 | (8'h04 << k[1:0]));
      rc(3'h0, 8'h20 + k[7:0]);
    end
    rc(3'h5, 8'h60);
    // Polled mode, then overrun on a full fifo.
    host.wr(3'h1, 8'hE0);
    for (k = 0; k < 8; k++) push(k[7:0], 3'h0);
    rc(3'h5, 8'h61);
    chk({7'h00, irq}, 8'h00);
    push(8'hFF, 3'h0);
    rc(3'h5, 8'h63);
    rc(3'h5, 8'h61);
    host.wr(3'h1, 8'hE4);
    push(8'hFE, 3'h0);
    wirq(1'b1);
    rc(3'h2, 8'hC6);
    rc(3'h5, 8'h63);
    wirq(1'b0);
    host.wr(3'h2, 8'h43);
    rc(3'h5, 8'h60);
    // Non-fifo mode: one held character raises the receive interrupt.
    host.wr(3'h2, 8'h00);
    host.wr(3'h1, 8'h01);
    push(8'h55, 3'h0);
    wirq(1'b1);
    rc(3'h2, 8'h04);
    rc(3'h0, 8'h55);
    // A data write in the normal page goes to the transmitter; modem status ignores writes.
    host.wr(3'h0, 8'h5C);
    host.wr(3'h6, 8'h00);
    rc(3'h6, 8'hA5);
    wirq(1'b0);
    // Mask bits 1, 3, 5 and the pair 7:6 each let through only their own source.
    ev = 1'b1;
    for (k = 0; k < 4; k++) begin
      host.wr(3'h1, masks[k]);
      wirq(1'b1);
      rc(3'h2, codes[k]);
    end
    ev = 1'b0;
    host.wr(3'h1, 8'h00);
    wirq(1'b0);
    // Transmit status bits move apart from the receive bits, first without and then with fifos.
    for (k = 0; k < 16; k++) begin
      if (k == 8) begin
        host.wr(3'h2, 8'h05);
      end
      tx_hold_empty = k[2];
      tx_fifo_empty = k[1];
      tx_shift_empty = k[0];
      rc(3'h5, {1'b0, (k[3] ? k[1] : k[2]) & k[0], k[3] ? k[1] : k[2], 5'h00});
    end
    summarize();
  end
endmodule
`default_nettype wire
